// ==== logic/sspg_pkg.sv ====
// Package: command codes, field layouts and delay encodings for the status and power-good block
package sspg_pkg;
  // Command codes
  localparam logic [7:0] CMD_FAULT_STATUS_BLOCK = 8'hdb;
  localparam logic [7:0] CMD_PHASE_FAULT_MAP = 8'hdc;
  localparam logic [7:0] CMD_POWER_GOOD_SETUP = 8'he3;
  // Response lengths in bytes
  localparam logic [3:0] LEN_STATUS_BLOCK = 4'h7;
  localparam logic [3:0] LEN_WORD = 4'h2;
  localparam logic [3:0] LEN_NONE = 4'h0;
  // Phase selection
  localparam logic [7:0] PHASE_ALL = 8'hff;
  localparam int NUM_PHASES = 4;
  // Communication status layout
  localparam int CML_INVALID_CMD_BIT = 7;
  // Power-good setup layout
  localparam int PGS_DROP_MSB = 15;
  localparam int PGS_DROP_LSB = 12;
  localparam int PGS_REL_MSB = 11;
  localparam int PGS_REL_LSB = 8;
  localparam int PGS_MASK_MSB = 7;
  localparam logic [15:0] PGS_RESET = 16'h0000;
  // Delay encoding: code 0 is one PWM clock, code N is 2^N+1
  localparam logic [16:0] DELAY_ZERO_TICKS = 17'h00001;
  localparam int DELAY_CNT_W = 17;

  function automatic logic [16:0] delay_ticks(input logic [3:0] code);
    logic [16:0] t;
    t = DELAY_ZERO_TICKS;
    if (code != 4'h0) begin
      t = (17'h00001 << code) + 17'h00001;
    end
    return t;
  endfunction
endpackage

// ==== logic/sspg_pg_if.sv ====
// Interface: link between register logic and power-good delay timer
`timescale 1ns/100ps
interface sspg_pg_if;
  logic tick;
  logic fault;
  logic force_low;
  logic bypass;
  logic [3:0] drop_code;
  logic [3:0] rel_code;
  logic good;
  modport ctrl (output tick, output fault, output force_low, output bypass,
                output drop_code, output rel_code, input good);
  modport timer (input tick, input fault, input force_low, input bypass,
                 input drop_code, input rel_code, output good);
endinterface

// ==== logic/sspg_pg_timer.sv ====
// Power-good delay timer: independent drop and release delays in PWM clocks
`timescale 1ns/100ps
module sspg_pg_timer
  import sspg_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control link
  sspg_pg_if.timer pg
);
  logic [16:0] drop_cnt_q;
  logic [16:0] rel_cnt_q;
  logic good_q;
  logic [16:0] drop_lim;
  logic [16:0] rel_lim;

  assign drop_lim = delay_ticks(pg.drop_code);
  assign rel_lim = delay_ticks(pg.rel_code);
  assign pg.good = good_q;

  ////////////////////////////////////////////////////////////////////////////
  // Drop delay counter, runs only while an unmasked event stands
  always_ff @(posedge i_clk) begin
    if (i_rst || !pg.fault || pg.force_low) begin
      drop_cnt_q <= '0;
    end else if (pg.tick && drop_cnt_q < drop_lim) begin
      drop_cnt_q <= drop_cnt_q + 17'h00001;
    end
  end

  // Release delay counter, runs only while no unmasked event stands
  always_ff @(posedge i_clk) begin
    if (i_rst || pg.fault || pg.force_low) begin
      rel_cnt_q <= '0;
    end else if (pg.tick && rel_cnt_q < rel_lim) begin
      rel_cnt_q <= rel_cnt_q + 17'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output state; a short event that never reaches its drop count is absorbed unless bypass is set
  always_ff @(posedge i_clk) begin
    if (i_rst || pg.force_low) begin
      good_q <= 1'b0;
    end else if (pg.fault && pg.bypass) begin
      good_q <= 1'b0;
    end else if (good_q && pg.fault && pg.tick && drop_cnt_q + 17'h00001 >= drop_lim) begin
      good_q <= 1'b0;
    end else if (!good_q && !pg.fault && pg.tick && rel_cnt_q + 17'h00001 >= rel_lim) begin
      good_q <= 1'b1;
    end
  end
endmodule

// ==== logic/sspg_status_power_good_out.sv ====
// Status summary, phase fault map and power-good setup command registers
`timescale 1ns/100ps
module sspg_status_power_good_out
  import sspg_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  // Decoded command port from the bus transaction layer
  input wire logic [7:0] i_cmd_code,
  input wire logic i_wr_stb,
  input wire logic [15:0] i_wr_data,
  input wire logic i_rd_stb,
  input wire logic i_clear_faults,
  output logic [55:0] o_rd_data,
  output logic [3:0] o_rd_len,
  output logic o_rd_valid,
  // Status sources
  input wire logic [7:0] i_maker_status_byte,
  input wire logic [7:0] i_status_other,
  input wire logic [7:0] i_status_cml,
  input wire logic [7:0] i_status_temp,
  input wire logic [7:0] i_status_input,
  input wire logic [7:0] i_status_iout,
  input wire logic [7:0] i_status_vout,
  output logic o_cml_summary,
  output logic o_smb_alert_n,
  // Stack phases
  input wire logic [7:0] i_phase_sel,
  input wire logic [3:0] i_phase_active,
  input wire logic [3:0] i_phase_status,
  // Setup defaults
  input wire logic i_nvm_load,
  input wire logic [15:0] i_nvm_setup,
  // Converter state and power-good events
  input wire logic i_pwm_clk,
  input wire logic i_conv_on,
  input wire logic i_ramp_blank,
  input wire logic i_shutdown_fall,
  input wire logic [7:0] i_pg_events,
  output logic o_power_good_out
);
  logic pwm_meta_q;
  logic pwm_sync_q;
  logic pwm_prev_q;
  logic invalid_command_flag_q;
  logic [3:0] phase_latch_q;
  logic [15:0] power_good_setup_q;
  logic [7:0] cml_byte;
  logic [15:0] phase_word;
  logic bad_write;
  sspg_pg_if pg ();

  ////////////////////////////////////////////////////////////////////////////
  // PWM clock sampled into the system clock; its rising edge is the tick
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      pwm_meta_q <= 1'b0;
      pwm_sync_q <= 1'b0;
      pwm_prev_q <= 1'b0;
    end else begin
      pwm_meta_q <= i_pwm_clk;
      pwm_sync_q <= pwm_meta_q;
      pwm_prev_q <= pwm_sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write checks
  always_comb begin
    bad_write = 1'b0;
    if (i_wr_stb && i_cmd_code == CMD_FAULT_STATUS_BLOCK) begin
      bad_write = 1'b1;
    end
    if (i_wr_stb && i_cmd_code == CMD_POWER_GOOD_SETUP && i_conv_on) begin
      bad_write = 1'b1;
    end
  end

  // Invalid command flag; a new fault wins over a clear in the same cycle
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      invalid_command_flag_q <= 1'b0;
    end else if (bad_write) begin
      invalid_command_flag_q <= 1'b1;
    end else if (i_clear_faults) begin
      invalid_command_flag_q <= 1'b0;
    end
  end

  // Live communication byte with the invalid command flag merged in
  always_comb begin
    cml_byte = i_status_cml;
    cml_byte[CML_INVALID_CMD_BIT] = i_status_cml[CML_INVALID_CMD_BIT] | invalid_command_flag_q;
  end

  // Summary bit and alert line; writes never clear source bits
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      o_cml_summary <= 1'b0;
      o_smb_alert_n <= 1'b1;
    end else begin
      o_cml_summary <= |cml_byte | bad_write;
      o_smb_alert_n <= ~(invalid_command_flag_q | bad_write);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-phase fault latches; a write of 1 clears, a live fault wins
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      phase_latch_q <= '0;
    end else begin
      for (int p = 0; p < NUM_PHASES; p++) begin
        if (i_phase_status[p] && i_phase_active[p]) begin
          phase_latch_q[p] <= 1'b1;
        end else if (i_wr_stb && i_cmd_code == CMD_PHASE_FAULT_MAP && i_wr_data[p]) begin
          phase_latch_q[p] <= 1'b0;
        end
      end
    end
  end

  // Phased read word
  always_comb begin
    phase_word = '0;
    if (i_phase_sel == PHASE_ALL) begin
      phase_word[NUM_PHASES-1:0] = phase_latch_q & i_phase_active;
    end else if (i_phase_sel < 8'(NUM_PHASES)) begin
      phase_word[0] = i_phase_active[i_phase_sel[1:0]] & i_phase_status[i_phase_sel[1:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-good setup word; reset loads zero, the default comes from storage or strap load
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      power_good_setup_q <= PGS_RESET;
    end else if (i_nvm_load) begin
      power_good_setup_q <= i_nvm_setup;
    end else if (i_wr_stb && i_cmd_code == CMD_POWER_GOOD_SETUP && !i_conv_on) begin
      power_good_setup_q <= i_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answers, one cycle after the strobe
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      o_rd_data <= '0;
      o_rd_len <= LEN_NONE;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_stb;
      if (i_rd_stb) begin
        unique case (i_cmd_code)
          CMD_FAULT_STATUS_BLOCK: begin
            o_rd_data <= {i_maker_status_byte, i_status_other, cml_byte, i_status_temp,
                          i_status_input, i_status_iout, i_status_vout};
            o_rd_len <= LEN_STATUS_BLOCK;
          end
          CMD_PHASE_FAULT_MAP: begin
            o_rd_data <= {40'h0000000000, phase_word};
            o_rd_len <= LEN_WORD;
          end
          CMD_POWER_GOOD_SETUP: begin
            o_rd_data <= {40'h0000000000, power_good_setup_q};
            o_rd_len <= LEN_WORD;
          end
          default: begin
            o_rd_data <= '0;
            o_rd_len <= LEN_NONE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-good path
  assign pg.tick = pwm_sync_q & ~pwm_prev_q;
  assign pg.fault = |(i_pg_events & ~power_good_setup_q[PGS_MASK_MSB:0]);
  assign pg.force_low = ~i_conv_on | i_ramp_blank;
  assign pg.bypass = i_shutdown_fall;
  assign pg.drop_code = power_good_setup_q[PGS_DROP_MSB:PGS_DROP_LSB];
  assign pg.rel_code = power_good_setup_q[PGS_REL_MSB:PGS_REL_LSB];

  sspg_pg_timer u_timer (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .pg(pg.timer)
  );

  // Extra flop keeps the pin straight from a register
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      o_power_good_out <= 1'b0;
    end else begin
      o_power_good_out <= pg.good & ~pg.force_low;
    end
  end
endmodule

// ==== testbench/sspg_status_power_good_out_monitor.sv ====
// Checker for the command port, phase map and power-good output
`timescale 1ns/100ps
module sspg_status_power_good_out_monitor
  import sspg_pkg::*;
(
  // Clock, reset and requests
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_maker_status_byte,
  input wire logic [7:0] i_status_vout,
  input wire logic [7:0] i_phase_sel,
  input wire logic [3:0] i_phase_active,
  input wire logic [3:0] i_phase_status,
  input wire logic i_conv_on,
  input wire logic i_ramp_blank,
  // Answers
  input wire logic [55:0] o_rd_data,
  input wire logic [3:0] o_rd_len,
  input wire logic o_rd_valid,
  input wire logic o_cml_summary,
  input wire logic o_smb_alert_n,
  input wire logic o_power_good_out
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);
  ////////////////////////////////////////////////////////////////
  read_answer_a: assert property (i_rd_stb |=> o_rd_valid) else $error("read not answered");
  no_stray_a: assert property (!i_rd_stb |=> !o_rd_valid) else $error("answer without read");
  block_order_a: assert property (i_rd_stb && i_cmd_code == CMD_FAULT_STATUS_BLOCK
    |=> o_rd_len == LEN_STATUS_BLOCK
    && o_rd_data[55:48] == $past(i_maker_status_byte) && o_rd_data[7:0] == $past(i_status_vout))
    else $error("status block layout wrong");
  bad_write_a: assert property (i_wr_stb && i_cmd_code == CMD_FAULT_STATUS_BLOCK
    |=> !o_smb_alert_n && o_cml_summary)
    else $error("block write not flagged");
  setup_lock_a: assert property (i_wr_stb && i_cmd_code == CMD_POWER_GOOD_SETUP && i_conv_on
    |=> !o_smb_alert_n)
    else $error("setup write while on not refused");
  map_reserved_a: assert property (i_rd_stb && i_cmd_code == CMD_PHASE_FAULT_MAP
    |=> o_rd_data[55:4] == '0)
    else $error("map upper bits set");
  one_phase_a: assert property (i_rd_stb && i_cmd_code == CMD_PHASE_FAULT_MAP && i_phase_sel < 8'h04
    |=> o_rd_data[0] == $past(i_phase_active[i_phase_sel[1:0]] & i_phase_status[i_phase_sel[1:0]])
    && o_rd_data[3:1] == '0)
    else $error("single phase bit wrong");
  unused_phase_a: assert property (i_rd_stb && i_cmd_code == CMD_PHASE_FAULT_MAP && i_phase_sel > 8'h03
    && i_phase_sel != PHASE_ALL |=> o_rd_data[15:0] == 16'h0000) else $error("unused phase nonzero");
  forced_low_a: assert property (!i_conv_on || i_ramp_blank |=> !o_power_good_out)
    else $error("power good high while forced");
endmodule
bind sspg_status_power_good_out sspg_status_power_good_out_monitor mon (.I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST),
  .i_cmd_code(i_cmd_code), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .i_maker_status_byte(i_maker_status_byte),
  .i_status_vout(i_status_vout), .i_phase_sel(i_phase_sel), .i_phase_active(i_phase_active),
  .i_phase_status(i_phase_status), .i_conv_on(i_conv_on), .i_ramp_blank(i_ramp_blank), .o_rd_data(o_rd_data),
  .o_rd_len(o_rd_len), .o_rd_valid(o_rd_valid), .o_cml_summary(o_cml_summary), .o_smb_alert_n(o_smb_alert_n),
  .o_power_good_out(o_power_good_out));

// ==== testbench/sspg_host_model.sv ====
// Host model driving the decoded command port
`timescale 1ns/100ps
module sspg_host_model (
  // Clock
  input wire logic i_clk,
  // Requests
  output logic [7:0] o_cmd,
  output logic o_wr_stb,
  output logic [15:0] o_wr_data,
  output logic o_rd_stb,
  output logic o_clear,
  // Answers
  input wire logic [55:0] i_rd_data,
  input wire logic [3:0] i_rd_len,
  input wire logic i_rd_valid
);
  initial begin
    o_cmd = 8'h00;
    o_wr_stb = 1'b0;
    o_wr_data = 16'h0000;
    o_rd_stb = 1'b0;
    o_clear = 1'b0;
  end
  // Block command written only where a refusal is wanted
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    @(posedge i_clk);
    o_cmd <= c;
    o_wr_data <= v;
    o_wr_stb <= 1'b1;
    @(posedge i_clk);
    o_wr_stb <= 1'b0;
    o_wr_data <= ~v;
  endtask
  task automatic rd(input logic [7:0] c, output logic [59:0] r);
    @(posedge i_clk);
    o_cmd <= c;
    o_rd_stb <= 1'b1;
    @(posedge i_clk);
    o_rd_stb <= 1'b0;
    #1;
    r = {i_rd_len, i_rd_data};
    // Answer must come exactly one cycle on; a late one spoils the word
    if (i_rd_valid !== 1'b1) begin
      r = '1;
    end
  endtask
  task automatic clr;
    @(posedge i_clk);
    o_clear <= 1'b1;
    @(posedge i_clk);
    o_clear <= 1'b0;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// Testbench for the status summary and power-good setup block
`timescale 1ns/100ps
module tb_top
  import sspg_pkg::*;
;
  logic clk, rst, pwm, ld, on, blank, shut, wr, rd, clr, vld, cml, al_n, pg;
  logic [7:0] cmd, sel, ev;
  logic [15:0] wd, nv;
  logic [3:0] act, phs, len;
  logic [55:0] rdd;
  logic [55:0] sb = 56'h81420024183c5a;
  logic [59:0] r;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  sspg_status_power_good_out dut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .i_cmd_code(cmd), .i_wr_stb(wr), .i_wr_data(wd),
    .i_rd_stb(rd), .i_clear_faults(clr), .o_rd_data(rdd), .o_rd_len(len), .o_rd_valid(vld),
    .i_maker_status_byte(sb[55:48]), .i_status_other(sb[47:40]), .i_status_cml(sb[39:32]),
    .i_status_temp(sb[31:24]), .i_status_input(sb[23:16]), .i_status_iout(sb[15:8]), .i_status_vout(sb[7:0]),
    .o_cml_summary(cml), .o_smb_alert_n(al_n), .i_phase_sel(sel), .i_phase_active(act), .i_phase_status(phs),
    .i_nvm_load(ld), .i_nvm_setup(nv), .i_pwm_clk(pwm), .i_conv_on(on), .i_ramp_blank(blank),
    .i_shutdown_fall(shut), .i_pg_events(ev), .o_power_good_out(pg));
  sspg_host_model host (.i_clk(clk), .o_cmd(cmd), .o_wr_stb(wr), .o_wr_data(wd), .o_rd_stb(rd), .o_clear(clr),
    .i_rd_data(rdd), .i_rd_len(len), .i_rd_valid(vld));
  ////////////////////////////////////////////////////////////////
  task check(input logic [59:0] seen, input logic [59:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Returns on the edge itself so that the next drive lands on that edge
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // PWM clock, phase unrelated to the system clock
  initial begin
    pwm = 1'b0;
    #3;
    forever #40 pwm = ~pwm;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      conclude;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {rst, ld, on, blank, shut, sel, ev, act, phs} = {4'h8, 1'b0, 8'hff, 8'h00, 4'h5, 4'h7};
    nv = 16'h5a3c;
    tick(10);
    rst <= 1'b0;
    host.rd(CMD_FAULT_STATUS_BLOCK, r);
    check(r, {LEN_STATUS_BLOCK, sb});
    host.wr(CMD_FAULT_STATUS_BLOCK, 16'hffff);
    #1 check({58'h0, al_n, cml}, 60'h1);
    host.rd(CMD_FAULT_STATUS_BLOCK, r);
    check(r, {LEN_STATUS_BLOCK, sb | 56'h00008000000000});
    host.clr;
    // Alert and summary follow the cleared flag one register later
    tick(1);
    #1 check({58'h0, al_n, cml}, 60'h2);
    host.rd(CMD_PHASE_FAULT_MAP, r);
    check(r, {LEN_WORD, 56'h5});
    tick(1);
    phs <= 4'h6;
    host.wr(CMD_PHASE_FAULT_MAP, 16'h0001);
    host.rd(CMD_PHASE_FAULT_MAP, r);
    check(r, {LEN_WORD, 56'h4});
    for (int i = 0; i < 6; i++) begin
      tick(1);
      sel <= 8'(i);
      host.rd(CMD_PHASE_FAULT_MAP, r);
      check(r, {LEN_WORD, 55'h0, i == 2});
    end
    tick(1);
    ld <= 1'b1;
    tick(1);
    ld <= 1'b0;
    host.rd(CMD_POWER_GOOD_SETUP, r);
    check(r, {LEN_WORD, 56'h5a3c});
    host.wr(CMD_POWER_GOOD_SETUP, 16'h1080);
    on <= 1'b1;
    host.wr(CMD_POWER_GOOD_SETUP, 16'hffff);
    #1 check({59'h0, al_n}, 60'h0);
    host.rd(CMD_POWER_GOOD_SETUP, r);
    check(r, {LEN_WORD, 56'h1080});
    tick(40);
    ev <= 8'h80;
    #1 check(pg, 1);
    tick(60);
    ev <= 8'h40;
    #1 check(pg, 1);
    // Three PWM ticks are needed to drop; ten cycles hold at most two
    tick(10);
    #1 check(pg, 1);
    tick(40);
    ev <= 8'h00;
    #1 check(pg, 0);
    tick(40);
    blank <= 1'b1;
    #1 check(pg, 1);
    tick(2);
    #1 check(pg, 0);
    tick(1);
    blank <= 1'b0;
    tick(40);
    shut <= 1'b1;
    ev <= 8'h40;
    #1 check(pg, 1);
    tick(3);
    #1 check(pg, 0);
    conclude;
  end
endmodule
